/* shared/eep_pkg.sv */
// Constants and types shared by the serial memory front end.
// Assumes a single 100 MHz clock and a two-wire bus sampled as plain inputs.
package eep_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_FREQ_KHZ = 100_000;
  localparam int EW_TIME_MS = 7;
  localparam int EW_CYCLES = EW_TIME_MS * CLK_FREQ_KHZ;
  localparam int EW_CNT_W = 20;
  localparam int POR_TIME_US = 10;
  localparam int BUS_MAX_KHZ = 100;

  // ==========================================================================
  // Address byte layout
  // The device type code is arbitrary and neutral.
  localparam logic [3:0] DEV_TYPE_ID = 4'h6;
  localparam int TYPE_LSB = 4;
  localparam int CS_BIT = 3;
  localparam int PAGE_LSB = 1;
  localparam int RW_BIT = 0;
  localparam int UPPER_HALF_BIT = 9;

  // ==========================================================================
  // Widths and counts
  localparam int WORD_W = 10;
  localparam int BYTE_W = 8;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] PAGE_BYTES = 4'h8;
  localparam logic [3:0] PAGE_WRITE_UNITS = 4'h9;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================================
  // Transfer phases, Gray coded along the write path.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_WORD = 3'h3,
    ST_WDATA = 3'h2,
    ST_RDATA = 3'h6,
    ST_IGNORE = 3'h7
  } eep_state_t;

endpackage

/* design/eep_slave.sv */
// Two-wire slave front end of a 1024-byte memory, with its write FIFO.
// Assumes an open-drain bus resolved outside, a memory that returns read
// data one clock after a read request, and a memory write port with ready.
`timescale 1ns/1ps

// ============================================================================
// Write FIFO
module eep_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
    $error("FIFO depth must be a power of two of at least two.");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } eep_fifo_regs_t;

  eep_fifo_regs_t q;
  eep_fifo_regs_t r;

  assign inReady = !((q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]));
  assign outValid = (q.wr != q.rd);
  assign outData = q.mem[q.rd[AW-1:0]];

  always_comb begin
    r = q;
    if (inValid && inReady) begin
      r.mem[q.wr[AW-1:0]] = inData;
      r.wr = q.wr + (AW+1)'(1);
    end
    if (outValid && outReady) begin
      r.rd = q.rd + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= r;
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
    (inValid && !inReady) |=> (q.wr == $past(q.wr)))
    else $error("FIFO wrote while full.");
endmodule // eep_fifo

module eep_slave #(
  parameter int EW_CYCLES = eep_pkg::EW_CYCLES,
  parameter int FIFO_DEPTH = eep_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic chipSelectAddressPin,
  input wire logic writeProtect,
  output logic rdReq,
  output logic [eep_pkg::WORD_W-1:0] rdAddr,
  input wire logic [eep_pkg::BYTE_W-1:0] rdData,
  output logic memWrValid,
  input wire logic memWrReady,
  output logic [eep_pkg::WORD_W-1:0] memWrAddr,
  output logic [eep_pkg::BYTE_W-1:0] memWrData,
  output logic eraseWriteBusy
);
  localparam int FW = eep_pkg::WORD_W + eep_pkg::BYTE_W;

  if (EW_CYCLES < 1 || EW_CYCLES >= (1 << eep_pkg::EW_CNT_W)) begin : g_ew_chk
    $error("Write cycle count does not fit the timer.");
  end

  typedef logic [eep_pkg::EW_CNT_W-1:0] eep_ewcnt_t;

  typedef struct packed {
    logic [2:0] sclS;
    logic [2:0] sdaS;
    logic [1:0] csS;
    logic [1:0] wpS;
    eep_pkg::eep_state_t st;
    logic [3:0] bitCnt;
    logic ackSlot;
    logic [7:0] rxShift;
    logic [7:0] txShift;
    logic sdaOeN;
    logic [9:0] wordAddr;
    logic [9:0] startAddr;
    logic [3:0] wrCount;
    logic discard;
    logic [7:0][7:0] pageBuf;
    logic rdReq;
    logic rdLoad;
    logic busy;
    logic [3:0] ewUnits;
    logic [3:0] pushIdx;
    eep_ewcnt_t ewTimer;
  } eep_regs_t;

  eep_regs_t q;
  eep_regs_t r;

  // ==========================================================================
  // Bus condition detection
  // Stage [0] of each synchroniser feeds only stage [1]; [2] holds the last
  // synchronised level for edge finding. At 100 MHz even a 100 kHz bus gives
  // hundreds of samples per clock phase, so no glitch filter is needed.
  logic sclRise;
  logic sclFall;
  logic sclHigh;
  logic sdaBit;
  logic startDet;
  logic stopDet;
  logic byteEnd;
  logic addrHit;
  logic wpHit;
  logic pushValid;
  logic pushReady;
  logic [2:0] pushLow;
  logic [FW-1:0] pushData;

  assign sclRise = q.sclS[1] && !q.sclS[2];
  assign sclFall = !q.sclS[1] && q.sclS[2];
  assign sclHigh = q.sclS[1] && q.sclS[2];
  assign sdaBit = q.sdaS[1];
  assign startDet = sclHigh && !q.sdaS[1] && q.sdaS[2];
  assign stopDet = sclHigh && q.sdaS[1] && !q.sdaS[2];
  assign byteEnd = sclFall && !q.ackSlot && (q.bitCnt == eep_pkg::BIT_ACK);
  assign addrHit = !q.busy
    && (q.rxShift[eep_pkg::TYPE_LSB+:4] == eep_pkg::DEV_TYPE_ID)
    && (q.rxShift[eep_pkg::CS_BIT] == q.csS[1]);
  assign wpHit = q.wpS[1] && q.wordAddr[eep_pkg::UPPER_HALF_BIT];

  // ==========================================================================
  // Commit of the page buffer into the FIFO
  assign pushValid = q.busy && (q.pushIdx != q.wrCount);
  assign pushLow = q.startAddr[2:0] + q.pushIdx[2:0];
  assign pushData = {q.startAddr[9:3], pushLow, q.pageBuf[q.pushIdx[2:0]]};

  logic [FW-1:0] fifoOut;

  eep_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(memWrValid),
    .outReady(memWrReady),
    .outData(fifoOut)
  );

  assign memWrAddr = fifoOut[FW-1:eep_pkg::BYTE_W];
  assign memWrData = fifoOut[eep_pkg::BYTE_W-1:0];
  assign sdaOut = 1'b0;
  assign sdaOeN = q.sdaOeN;
  assign rdReq = q.rdReq;
  assign rdAddr = q.wordAddr;
  assign eraseWriteBusy = q.busy;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    r = q;
    r.sclS = {q.sclS[1:0], scl};
    r.sdaS = {q.sdaS[1:0], sdaIn};
    r.csS = {q.csS[0], chipSelectAddressPin};
    r.wpS = {q.wpS[0], writeProtect};
    r.rdReq = 1'b0;
    r.rdLoad = q.rdReq;
    if (q.rdLoad) begin
      r.txShift = rdData;
    end
    // The cycle also waits until every page byte has been pushed into the FIFO,
    // so a full FIFO lengthens it instead of losing bytes.
    if (q.busy) begin
      if (pushValid && pushReady) begin
        r.pushIdx = q.pushIdx + 4'h1;
      end
      if (q.ewTimer != '0) begin
        r.ewTimer = q.ewTimer - eep_ewcnt_t'(1);
      end else if (q.ewUnits != 4'h0) begin
        r.ewUnits = q.ewUnits - 4'h1;
        r.ewTimer = eep_ewcnt_t'(EW_CYCLES - 1);
      end else if (q.pushIdx == q.wrCount) begin
        r.busy = 1'b0;
      end
    end
    if (startDet) begin
      // A repeated start drops any unfinished write, as a random read needs.
      r.st = eep_pkg::ST_ADDR;
      r.bitCnt = 4'h0;
      r.ackSlot = 1'b0;
      r.sdaOeN = 1'b1;
    end else if (stopDet) begin
      if (q.st == eep_pkg::ST_WDATA && q.wrCount != 4'h0 && !q.discard && !q.busy) begin
        r.busy = 1'b1;
        r.pushIdx = 4'h0;
        r.ewTimer = eep_ewcnt_t'(EW_CYCLES - 1);
        if (q.wrCount == eep_pkg::PAGE_BYTES) begin
          r.ewUnits = eep_pkg::PAGE_WRITE_UNITS - 4'h1;
        end else begin
          r.ewUnits = q.wrCount - 4'h1;
        end
      end
      r.st = eep_pkg::ST_IDLE;
      r.sdaOeN = 1'b1;
      r.ackSlot = 1'b0;
      r.bitCnt = 4'h0;
    end else if (q.st != eep_pkg::ST_IDLE) begin
      if (sclRise) begin
        if (q.ackSlot) begin
          // The address acknowledge slot is ours and still driven low; only a
          // released slot belongs to the master and may advance the address.
          if (q.st == eep_pkg::ST_RDATA && q.sdaOeN) begin
            r.wordAddr[7:0] = q.wordAddr[7:0] + 8'h01;
            if (sdaBit) begin
              r.st = eep_pkg::ST_IGNORE;
            end else begin
              r.rdReq = 1'b1;
            end
          end
        end else if (q.bitCnt != eep_pkg::BIT_ACK) begin
          r.rxShift = {q.rxShift[6:0], sdaBit};
          r.bitCnt = q.bitCnt + 4'h1;
        end
      end else if (sclFall) begin
        if (q.ackSlot) begin
          r.ackSlot = 1'b0;
          r.bitCnt = 4'h0;
          r.sdaOeN = 1'b1;
          if (q.st == eep_pkg::ST_RDATA) begin
            r.sdaOeN = q.txShift[7];
            r.txShift = {q.txShift[6:0], 1'b0};
          end
        end else if (byteEnd) begin
          r.ackSlot = 1'b1;
          case (q.st)
            eep_pkg::ST_ADDR: begin
              if (addrHit) begin
                r.sdaOeN = 1'b0;
                r.wordAddr[9:8] = q.rxShift[eep_pkg::PAGE_LSB+:2];
                if (q.rxShift[eep_pkg::RW_BIT]) begin
                  r.st = eep_pkg::ST_RDATA;
                  r.rdReq = 1'b1;
                end else begin
                  r.st = eep_pkg::ST_WORD;
                end
              end else begin
                r.st = eep_pkg::ST_IGNORE;
              end
            end
            eep_pkg::ST_WORD: begin
              r.sdaOeN = 1'b0;
              r.wordAddr[7:0] = q.rxShift;
              r.startAddr = {q.wordAddr[9:8], q.rxShift};
              r.wrCount = 4'h0;
              r.discard = 1'b0;
              r.st = eep_pkg::ST_WDATA;
            end
            eep_pkg::ST_WDATA: begin
              if (wpHit || q.wrCount == eep_pkg::PAGE_BYTES) begin
                r.discard = 1'b1;
              end else begin
                r.pageBuf[q.wrCount[2:0]] = q.rxShift;
                r.wrCount = q.wrCount + 4'h1;
                r.wordAddr[2:0] = q.wordAddr[2:0] + 3'h1;
                r.sdaOeN = 1'b0;
              end
            end
            default: begin
              r.sdaOeN = 1'b1;
            end
          endcase
        end else if (q.st == eep_pkg::ST_RDATA && q.bitCnt != 4'h0) begin
          r.sdaOeN = q.txShift[7];
          r.txShift = {q.txShift[6:0], 1'b0};
        end
      end
    end
  end

  // Reset takes one clock, far inside the power-on allowance; the scl and sda
  // synchronisers start at the idle bus level so no false edge follows release.
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.sclS <= 3'h7;
      q.sdaS <= 3'h7;
      q.sdaOeN <= 1'b1;
    end else begin
      q <= r;
    end
  end

  // ==========================================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  start_taken_a: assert property (
    startDet |=> (q.st == eep_pkg::ST_ADDR) && (q.bitCnt == 4'h0))
    else $error("Start condition not taken.");
  stop_release_a: assert property (
    stopDet |=> (q.st == eep_pkg::ST_IDLE) && q.sdaOeN)
    else $error("Stop did not release the bus.");
  sda_stable_a: assert property (
    $changed(q.sdaOeN) |-> $past(sclFall) || $past(startDet) || $past(stopDet))
    else $error("Data drive changed while clock high.");
  addr_ack_a: assert property (
    (byteEnd && q.st == eep_pkg::ST_ADDR && addrHit) |=> !q.sdaOeN && q.ackSlot)
    else $error("Matching address not acknowledged.");
  busy_nack_a: assert property (
    (byteEnd && q.st == eep_pkg::ST_ADDR && q.busy) |=> q.sdaOeN ##1 q.sdaOeN)
    else $error("Address acknowledged during write cycle.");
  page_select_a: assert property (
    (byteEnd && q.st == eep_pkg::ST_ADDR && addrHit)
      |=> q.wordAddr[9:8] == $past(q.rxShift[2:1]))
    else $error("Page bits not loaded.");
  read_dir_a: assert property (
    (byteEnd && q.st == eep_pkg::ST_ADDR && addrHit && q.rxShift[0])
      |=> (q.st == eep_pkg::ST_RDATA) && q.rdReq ##1 q.rdLoad)
    else $error("Read direction not started.");
  read_incr_a: assert property (
    (sclRise && q.ackSlot && q.sdaOeN && q.st == eep_pkg::ST_RDATA && !startDet && !stopDet)
      |=> (q.wordAddr[7:0] == $past(q.wordAddr[7:0]) + 8'h01)
        && (q.wordAddr[9:8] == $past(q.wordAddr[9:8])))
    else $error("Read address did not advance inside page.");
  page_wrap_a: assert property (
    (byteEnd && q.st == eep_pkg::ST_WDATA && !wpHit && q.wrCount != eep_pkg::PAGE_BYTES)
      |=> (q.wordAddr[2:0] == $past(q.wordAddr[2:0]) + 3'h1)
        && (q.wordAddr[9:3] == $past(q.wordAddr[9:3])))
    else $error("Page write address wrap wrong.");
  ninth_nack_a: assert property (
    (byteEnd && q.st == eep_pkg::ST_WDATA && q.wrCount == eep_pkg::PAGE_BYTES)
      |=> q.sdaOeN && q.discard)
    else $error("Ninth data byte acknowledged.");
  protect_nack_a: assert property (
    (byteEnd && q.st == eep_pkg::ST_WDATA && wpHit) |=> q.sdaOeN && q.discard)
    else $error("Protected byte acknowledged.");
  write_commit_a: assert property (
    (stopDet && q.st == eep_pkg::ST_WDATA && q.wrCount != 4'h0 && !q.discard && !q.busy)
      |=> q.busy && (q.pushIdx == 4'h0))
    else $error("Write cycle not started after stop.");
endmodule // eep_slave

/* tb/eep_bus_master.sv */
// Behavioural two-wire bus master for the serial memory front end.
// Assumes an open-drain bus with pull-up resolved by the bench, and a 100 MHz clk.
`timescale 1ns/1ps
module eep_bus_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sdaLow
);
  // ==========================================================================
  // Pacing
  // The bus clock is stepped off clk so every level lasts at least five cycles.
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ==========================================================================
  // Bit level
  task automatic bit_xfer(input logic b, output logic r);
    sdaLow = ~b;
    tick(3);
    scl = 1'b1;
    tick(4);
    r = sda;
    tick(1);
    scl = 1'b0;
    tick(2);
  endtask

  // Also serves as a repeated start when entered with the clock low.
  task automatic start_cond();
    scl = 1'b0;
    tick(2);
    sdaLow = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(5);
    sdaLow = 1'b1;
    tick(5);
    scl = 1'b0;
    tick(2);
  endtask

  task automatic stop_cond();
    sdaLow = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(5);
    sdaLow = 1'b0;
    tick(8);
  endtask

  // ==========================================================================
  // Byte level
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(last, r);
  endtask
endmodule // eep_bus_master

/* tb/eep_slave_test.sv */
// Self-checking bench for the serial memory front end.
// Assumes eep_pkg, eep_slave and eep_bus_master are compiled first.
`timescale 1ns/1ps
module eep_slave_test;
  localparam int EW = 50;
  logic clk = 1'b0;
  logic rst;
  logic csPin;
  logic wp;
  logic memWrReady;
  logic [7:0] rdData;
  logic scl, sdaLow, sdaOut, sdaOeN, rdReq, memWrValid, eraseWriteBusy;
  logic [9:0] rdAddr, memWrAddr;
  logic [7:0] memWrData;
  logic [7:0] mem [1024];
  logic [7:0] model [1024];
  logic [7:0] rb [16];
  int errors = 0;
  int comparisons = 0;
  int stallCnt = 0;
  wire sda = ~(sdaLow | (~sdaOeN & ~sdaOut));

  always #5 clk = ~clk;

  eep_slave #(.EW_CYCLES(EW), .FIFO_DEPTH(16)) u_dut (
    .clk(clk), .rst(rst), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .chipSelectAddressPin(csPin), .writeProtect(wp), .rdReq(rdReq), .rdAddr(rdAddr),
    .rdData(rdData), .memWrValid(memWrValid), .memWrReady(memWrReady),
    .memWrAddr(memWrAddr), .memWrData(memWrData), .eraseWriteBusy(eraseWriteBusy)
  );

  eep_bus_master u_master (.clk(clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));

  // ==========================================================================
  // Memory array model; the write port stalls one cycle in three.
  initial begin
    memWrReady = 1'b0;
    rdData = 8'h00;
    forever begin
      @(posedge clk);
      if (memWrValid === 1'b1 && memWrReady === 1'b1) mem[memWrAddr] = memWrData;
      #1;
      if (rdReq === 1'b1) rdData = mem[rdAddr];
      stallCnt++;
      memWrReady = (stallCnt % 3 != 0);
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_idle(output int ns);
    int t0;
    t0 = int'($time);
    for (int i = 0; i < 5000; i++) begin
      if (eraseWriteBusy === 1'b0) begin
        ns = int'($time) - t0;
        return;
      end
      u_master.tick(1);
    end
    errors++;
    $display("CHECK FAILED busy wait expected 0 seen 1");
    wrap_up();
  endtask

  task automatic write_seq(input logic [9:0] a, input int n, output logic [15:0] acks);
    logic ack;
    acks = 16'h0000;
    u_master.start_cond();
    u_master.send_byte({eep_pkg::DEV_TYPE_ID, csPin, a[9:8], 1'b0}, ack);
    acks[0] = ack;
    u_master.send_byte(a[7:0], ack);
    acks[1] = ack;
    for (int i = 0; i < n; i++) begin
      u_master.send_byte(8'hA0 + 8'(i), ack);
      acks[i + 2] = ack;
    end
    u_master.stop_cond();
  endtask

  task automatic read_chk(input logic [9:0] a, input logic rnd, input int n);
    logic ack;
    if (rnd) begin
      u_master.start_cond();
      u_master.send_byte({eep_pkg::DEV_TYPE_ID, csPin, a[9:8], 1'b0}, ack);
      u_master.send_byte(a[7:0], ack);
    end
    u_master.start_cond();
    u_master.send_byte({eep_pkg::DEV_TYPE_ID, csPin, a[9:8], 1'b1}, ack);
    chk("read address ack", 16'h0001, {15'h0000, ack});
    for (int i = 0; i < n; i++) u_master.recv_byte(i == n - 1, rb[i]);
    u_master.tick(3);
    chk("released after last byte", 16'h0001, {15'h0000, sdaOeN});
    u_master.stop_cond();
    for (int i = 0; i < n; i++)
      chk("read byte", {8'h00, model[{a[9:8], 8'(a[7:0] + 8'(i))}]}, {8'h00, rb[i]});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_page_write();
    logic [15:0] acks;
    logic ack;
    int ns;
    int tStop;
    logic timeOk;
    write_seq(10'h2FE, 8, acks);
    tStop = int'($time);
    chk("page write acks", 16'h03FF, acks);
    for (int i = 0; i < 8; i++) model[{7'h5F, 3'(3'h6 + 3'(i))}] = 8'hA0 + 8'(i);
    u_master.tick(2);
    chk("busy after stop", 16'h0001, {15'h0000, eraseWriteBusy});
    u_master.start_cond();
    u_master.send_byte({eep_pkg::DEV_TYPE_ID, csPin, 2'b10, 1'b1}, ack);
    u_master.stop_cond();
    chk("ack while busy", 16'h0000, {15'h0000, ack});
    wait_idle(ns);
    // Measured from the stop, since the busy probe above also spends bus time.
    ns = int'($time) - tStop;
    timeOk = (ns >= 9 * EW * 10 - 200) && (ns <= 9 * EW * 10 + 300);
    chk("page write time", 16'h0001, {15'h0000, timeOk});
    $display("test page_write done");
  endtask

  task automatic t_reads();
    read_chk(10'h2FC, 1'b1, 10);
    read_chk(10'h206, 1'b0, 2);
    $display("test reads done");
  endtask

  task automatic t_overrun();
    logic [15:0] acks;
    int ns;
    write_seq(10'h010, 9, acks);
    chk("overrun acks", 16'h03FF, acks);
    wait_idle(ns);
    read_chk(10'h010, 1'b1, 8);
    $display("test overrun done");
  endtask

  task automatic t_protect();
    logic [15:0] acks;
    int ns;
    wp = 1'b1;
    write_seq(10'h205, 1, acks);
    chk("protected acks", 16'h0003, acks);
    wait_idle(ns);
    write_seq(10'h005, 1, acks);
    chk("lower half acks", 16'h0007, acks);
    model[10'h005] = 8'hA0;
    wait_idle(ns);
    wp = 1'b0;
    read_chk(10'h204, 1'b1, 3);
    read_chk(10'h005, 1'b1, 1);
    $display("test protect done");
  endtask

  task automatic t_address();
    logic ack;
    logic [7:0] ab [3];
    for (int p = 0; p < 2; p++) begin
      csPin = 1'(p);
      u_master.tick(5);
      // Write direction, so an acknowledged probe leaves the data line free for the stop.
      ab[0] = {eep_pkg::DEV_TYPE_ID, csPin, 3'b000};
      ab[1] = {eep_pkg::DEV_TYPE_ID, ~csPin, 3'b000};
      ab[2] = {eep_pkg::DEV_TYPE_ID ^ 4'h1, csPin, 3'b000};
      for (int k = 0; k < 3; k++) begin
        u_master.start_cond();
        u_master.send_byte(ab[k], ack);
        u_master.stop_cond();
        chk("address ack", {15'h0000, k == 0}, {15'h0000, ack});
      end
    end
    csPin = 1'b0;
    u_master.tick(5);
    $display("test address done");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    csPin = 1'b0;
    wp = 1'b0;
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
      model[i] = 8'(i) ^ 8'h5A;
    end
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    u_master.tick(5);
    chk("idle after reset", 16'h0001, {15'h0000, sdaOeN});
    t_address();
    t_page_write();
    t_reads();
    t_overrun();
    t_protect();
    wrap_up();
  end
endmodule // eep_slave_test
